/* File: link_master.sv */
`default_nettype none
module link_master
   import rtc_pkg::*;
(
   // byte link toward the core
   input wire logic link_clk,
   output var bus_req_t link_req
);
   timeunit 1ns;
   timeprecision 100ps;
   initial link_req = '{start: 1'b0, wr: 1'b0, rd: 1'b0, data: 8'h00};
   task automatic send(input logic st, input logic wr, input logic rd, input logic [7:0] d);
      @(posedge link_clk);
      #1;
      link_req = '{start: st, wr: wr, rd: rd, data: d};
      @(posedge link_clk);
      #1;
      // idle data is the inverse of the last byte so a stale byte never looks fresh
      link_req = '{start: 1'b0, wr: 1'b0, rd: 1'b0, data: ~d};
      // six link cycles outlast the core cycles a time write needs to cross
      repeat (6) @(posedge link_clk);
      #1;
   endtask
   // every transfer opens with a start carrying the pointer
   task automatic begin_at(input logic [7:0] p);
      send(1'b1, 1'b0, 1'b0, p);
   endtask
   task automatic put(input logic [7:0] d);
      send(1'b0, 1'b1, 1'b0, d);
   endtask
   task automatic step();
      send(1'b0, 1'b0, 1'b1, 8'h00);
   endtask
endmodule
`default_nettype wire

/* File: rtc_core.sv */
// Contract
// - oscillator held stopped on first battery power until supply good or addressed
// - two seconds after supply or address, pulse a compensation request
// - first supply-up or addressed on battery loads 01/01/00 day 01 00:00:00
// - oscillator_enable_n high stops the oscillator and timekeeping
// - outside a reset cycle a reset-pin fall starts a driven-low debounce
// - still low after debounce: wait release, then drive a reset pulse
// - supply below power_fail_threshold leaves the reset pin undriven
// - supply return keeps the reset pin low for about 250ms
// - oscillator stopped at supply-up skips the recovery hold
// - reset pin only on main supply; reset never disturbs timekeeping
// - interrupt_control_select picks alarm irq or 1Hz square wave
// - month-end date rollover honours short months and leap February
// - 236 bytes of user memory at pointer 14h-FFh
// - multibyte pointer wraps from last register to zero
// - START or pointer wrap to zero snapshots time; reads come from snapshot
// - time and calendar held in BCD
// - hours bit 6 selects 12-hour; bit 5 is PM or twenty-hours
// - century bit toggles when year rolls 99 to 00
// - weekday increments at midnight, cycling sequential values
// - seconds write resets the countdown chain; writes land per byte
`default_nettype none
module rtc_core
   import rtc_pkg::*;
#(
   parameter int TICK_CYCLES = CLK_HZ,
   parameter int HOLD_CNT = HOLD_CYCLES,
   parameter int DEBOUNCE_CNT = DEBOUNCE_CYCLES,
   parameter int PULSE_CNT = RST_PULSE_CYCLES
)
(
   // system
   input wire logic clk,
   input wire logic reset_n,
   // byte link from the serial front end
   input wire logic link_clk,
   input wire logic link_reset_n,
   input wire bus_req_t link_req,
   output logic [7:0] link_rdata,
   // power and pins
   input wire logic supply_good,
   input wire logic oscillator_enable_n,
   input wire logic interrupt_control_select,
   input wire logic alarm_irq,
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   output logic alarm_irq_or_square_wave,
   output logic osc_running,
   output logic comp_request,
   output time_t time_now
);
   // ---------------- link domain: pointer, memory, snapshot ----------------
   logic [7:0] ptr_q;
   logic [7:0] sram_q [SRAM_BYTES];
   time_t snap_q;
   logic ev_tog_q;          // toggles once per time-register write event
   bus_req_t ev_q;          // held stable while crossing
   logic [7:0] ev_ptr_q;
   logic addr_seen_tog_q;
   logic [2:0] rd_addr_sel;
   time_t live_sync1_q, live_sync2_q;
   logic [7:0] ptr_next;

   always_comb
   begin
      ptr_next = (ptr_q == REG_LAST) ? 8'h00 : ptr_q + 8'h01;
      if (ptr_q >= SRAM_FIRST)
         ptr_next = ptr_q + 8'h01;
   end
   assign rd_addr_sel = ptr_q[2:0];

   // the time bus is slow-changing; a two-stage copy is safe because snapshots
   // are only taken at starts and pointer wraps to zero, well away from tick updates in practice
   always_ff @(posedge link_clk or negedge link_reset_n)
   begin
      if (!link_reset_n)
      begin
         live_sync1_q <= '0;
         live_sync2_q <= '0;
      end
      else
      begin
         live_sync1_q <= time_now;
         live_sync2_q <= live_sync1_q;
      end
   end

   always_ff @(posedge link_clk or negedge link_reset_n)
   begin
      if (!link_reset_n)
      begin
         ptr_q <= 8'h00;
         snap_q <= '0;
         ev_tog_q <= 1'b0;
         ev_q <= '0;
         ev_ptr_q <= 8'h00;
         addr_seen_tog_q <= 1'b0;
      end
      else
      begin
         if (link_req.start)
         begin
            snap_q <= live_sync2_q;
            ptr_q <= link_req.data;
            addr_seen_tog_q <= ~addr_seen_tog_q;
         end
         else if (link_req.wr || link_req.rd)
         begin
            ptr_q <= ptr_next;
            if (ptr_next == 8'h00)
               snap_q <= live_sync2_q;
         end
         if (link_req.wr && ptr_q <= REG_YEAR)
         begin
            ev_q <= link_req;
            ev_ptr_q <= ptr_q;
            ev_tog_q <= ~ev_tog_q;
         end
      end
   end

   always_ff @(posedge link_clk)
   begin
      if (link_req.wr && ptr_q >= SRAM_FIRST)
         sram_q[ptr_q - SRAM_FIRST] <= link_req.data;
   end

   always_ff @(posedge link_clk or negedge link_reset_n)
   begin
      if (!link_reset_n)
         link_rdata <= 8'h00;
      else if (ptr_q >= SRAM_FIRST)
         link_rdata <= sram_q[ptr_q - SRAM_FIRST];
      else if (ptr_q <= REG_YEAR)
         case (rd_addr_sel)
            3'd0: link_rdata <= snap_q.seconds;
            3'd1: link_rdata <= snap_q.minutes;
            3'd2: link_rdata <= snap_q.hours;
            3'd3: link_rdata <= snap_q.weekday;
            3'd4: link_rdata <= snap_q.date;
            3'd5: link_rdata <= snap_q.month;
            default: link_rdata <= snap_q.year;
         endcase
      else
         link_rdata <= 8'h00;
   end

   // ---------------- crossings into clk ----------------
   logic [2:0] ev_sync_q, addr_sync_q;
   logic [1:0] pg_sync_q, rp_sync_q;
   logic ev_pulse, addr_pulse, pg, rp;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ev_sync_q <= 3'b000;
         addr_sync_q <= 3'b000;
         pg_sync_q <= 2'b00;
         rp_sync_q <= 2'b11;
      end
      else
      begin
         ev_sync_q <= {ev_sync_q[1:0], ev_tog_q};
         addr_sync_q <= {addr_sync_q[1:0], addr_seen_tog_q};
         pg_sync_q <= {pg_sync_q[0], supply_good};
         rp_sync_q <= {rp_sync_q[0], reset_pin_in};
      end
   end
   assign ev_pulse = ev_sync_q[2] ^ ev_sync_q[1];
   assign addr_pulse = addr_sync_q[2] ^ addr_sync_q[1];
   assign pg = pg_sync_q[1];
   assign rp = rp_sync_q[1];

   // ---------------- power start-up ----------------
   logic pg_d1_q, started_q, seen_supply_q, osc_q;
   logic [31:0] comp_cnt_q;
   logic pg_rise;
   assign pg_rise = pg & ~pg_d1_q;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pg_d1_q <= 1'b0;
         started_q <= 1'b0;
         seen_supply_q <= 1'b0;
         osc_q <= 1'b0;
         comp_cnt_q <= '0;
         comp_request <= 1'b0;
      end
      else
      begin
         pg_d1_q <= pg;
         if (pg_rise || addr_pulse)
            started_q <= 1'b1;
         if (pg_rise)
            seen_supply_q <= 1'b1;
         osc_q <= (started_q || pg_rise || addr_pulse) && !oscillator_enable_n;
         comp_request <= 1'b0;
         if (pg_rise || addr_pulse)
            comp_cnt_q <= 32'(COMP_DELAY_S * TICK_CYCLES);
         else if (comp_cnt_q != 0)
         begin
            comp_cnt_q <= comp_cnt_q - 32'd1;
            comp_request <= (comp_cnt_q == 32'd1);
         end
      end
   end
   assign osc_running = osc_q;

   // first supply-up, or addressed on battery before any supply-up or earlier address, loads defaults
   logic load_defaults;
   assign load_defaults = (pg_rise && !seen_supply_q) || (addr_pulse && !pg && !started_q);

   // ---------------- timekeeping ----------------
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
   endfunction

   logic [31:0] div_q;
   logic tick, leap;
   logic [7:0] mdays;
   assign tick = osc_q && (div_q == 32'(TICK_CYCLES - 1));
   // year in BCD divisible by four: tens even with units 0,4,8 or tens odd with 2,6
   assign leap = time_now.year[4] ? (time_now.year[3:0] == 4'h2 || time_now.year[3:0] == 4'h6)
                                  : (time_now.year[1:0] == 2'b00);
   always_comb
   begin
      case (time_now.month[4:0])
         5'h02: mdays = leap ? 8'h29 : 8'h28;
         5'h04, 5'h06, 5'h09, 5'h11: mdays = 8'h30;
         default: mdays = 8'h31;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         div_q <= '0;
      else if (ev_pulse && ev_q.wr && ev_ptr_q == REG_SECONDS)
         div_q <= '0;
      else if (!osc_q || tick)
         div_q <= '0;
      else
         div_q <= div_q + 32'd1;
   end

   // reset pin activity never reaches this process
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         time_now <= '{RST_SECONDS, RST_MINUTES, RST_HOURS, RST_WEEKDAY, RST_DATE, RST_MONTH, RST_YEAR};
      else if (load_defaults)
         time_now <= '{RST_SECONDS, RST_MINUTES, RST_HOURS, RST_WEEKDAY, RST_DATE, RST_MONTH, RST_YEAR};
      else if (ev_pulse && ev_q.wr)
         case (ev_ptr_q[2:0])
            3'd0: time_now.seconds <= ev_q.data;
            3'd1: time_now.minutes <= ev_q.data;
            3'd2: time_now.hours <= ev_q.data;
            3'd3: time_now.weekday <= ev_q.data;
            3'd4: time_now.date <= ev_q.data;
            3'd5: time_now.month <= ev_q.data;
            default: time_now.year <= ev_q.data;
         endcase
      else if (tick)
      begin
         time_now.seconds <= bcd_inc(time_now.seconds);
         if (time_now.seconds == 8'h59)
         begin
            time_now.seconds <= 8'h00;
            time_now.minutes <= bcd_inc(time_now.minutes);
            if (time_now.minutes == 8'h59)
            begin
               time_now.minutes <= 8'h00;
               if (time_now.hours[HOUR_MODE12_BIT])
               begin
                  if (time_now.hours[4:0] == 5'h12)
                     time_now.hours[4:0] <= 5'h01;
                  else
                     time_now.hours[4:0] <= 5'(bcd_inc({3'b000, time_now.hours[4:0]}));
                  if (time_now.hours[4:0] == 5'h11)
                     time_now.hours[HOUR_PM_BIT] <= ~time_now.hours[HOUR_PM_BIT];
               end
               else if (time_now.hours[5:0] == 6'h23)
                  time_now.hours[5:0] <= 6'h00;
               else
                  time_now.hours[5:0] <= 6'(bcd_inc({2'b00, time_now.hours[5:0]}));
               if ((time_now.hours[HOUR_MODE12_BIT] && time_now.hours[5:0] == 6'h31)
                   || (!time_now.hours[HOUR_MODE12_BIT] && time_now.hours[5:0] == 6'h23))
               begin
                  time_now.weekday <= (time_now.weekday == 8'h07) ? 8'h01 : time_now.weekday + 8'h01;
                  time_now.date <= bcd_inc(time_now.date);
                  if (time_now.date == mdays)
                  begin
                     time_now.date <= 8'h01;
                     time_now.month[4:0] <= 5'(bcd_inc({3'b000, time_now.month[4:0]}));
                     if (time_now.month[4:0] == 5'h12)
                     begin
                        time_now.month[4:0] <= 5'h01;
                        time_now.year <= bcd_inc(time_now.year);
                        if (time_now.year == 8'h99)
                        begin
                           time_now.year <= 8'h00;
                           time_now.month[MONTH_CENTURY_BIT] <= ~time_now.month[MONTH_CENTURY_BIT];
                        end
                     end
                  end
               end
            end
         end
      end
   end

   // ---------------- square wave / interrupt pin ----------------
   logic half_q;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         half_q <= 1'b0;
         alarm_irq_or_square_wave <= 1'b0;
      end
      else
      begin
         if (!osc_q || tick)
            half_q <= 1'b0;
         else if (div_q == 32'(TICK_CYCLES / 2 - 1))
            half_q <= 1'b1;
         alarm_irq_or_square_wave <= interrupt_control_select ? alarm_irq : ~half_q;
      end
   end

   // ---------------- reset pin supervisor ----------------
   sup_state_t sup_q;
   logic [31:0] sup_cnt_q;
   logic rp_d1_q;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sup_q <= SUP_PFAIL;
         sup_cnt_q <= '0;
         rp_d1_q <= 1'b1;
         reset_pin_out <= 1'b0;
         reset_pin_oe <= 1'b1;
      end
      else
      begin
         rp_d1_q <= rp;
         if (sup_cnt_q != 0)
            sup_cnt_q <= sup_cnt_q - 32'd1;
         if (!pg)
            sup_q <= SUP_PFAIL;
         else
            case (sup_q)
               SUP_IDLE:
                  if (rp_d1_q && !rp)
                  begin
                     sup_q <= SUP_DEBOUNCE;
                     sup_cnt_q <= 32'(DEBOUNCE_CNT);
                  end
               SUP_DEBOUNCE:
                  if (sup_cnt_q == 0)
                     sup_q <= SUP_WAIT_RISE;
               SUP_WAIT_RISE:
                  if (rp && !rp_d1_q)
                  begin
                     sup_q <= SUP_PULSE;
                     sup_cnt_q <= 32'(PULSE_CNT);
                  end
                  else if (rp)
                     sup_q <= SUP_IDLE;
               SUP_PULSE:
                  if (sup_cnt_q == 0)
                     sup_q <= SUP_IDLE;
               SUP_PFAIL:
                  if (!osc_q)
                     sup_q <= SUP_IDLE;
                  else
                  begin
                     sup_q <= SUP_RECOVER;
                     sup_cnt_q <= 32'(HOLD_CNT);
                  end
               SUP_RECOVER:
                  if (sup_cnt_q == 0)
                     sup_q <= SUP_IDLE;
               default:
                  sup_q <= SUP_IDLE;
            endcase
         reset_pin_out <= 1'b0;
         // no main supply: the pin is not driven at all
         reset_pin_oe <= pg && (sup_q == SUP_DEBOUNCE || sup_q == SUP_PULSE || sup_q == SUP_RECOVER
                                || (sup_q == SUP_PFAIL && osc_q));
      end
   end
endmodule
`default_nettype wire

/* File: rtc_core_chk.sv */
`default_nettype none
module rtc_core_chk
   import rtc_pkg::*;
#(
   parameter int HOLD_CNT = HOLD_CYCLES
)
(
   // system
   input wire logic clk,
   input wire logic reset_n,
   // pins and controls
   input wire logic supply_good,
   input wire logic oscillator_enable_n,
   input wire logic interrupt_control_select,
   input wire logic alarm_irq,
   input wire logic reset_pin_in,
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   input wire logic alarm_irq_or_square_wave,
   input wire logic osc_running,
   input wire logic comp_request,
   input wire time_t time_now
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   logic [31:0] hold_q;
   logic recover_q;
   logic supply_q;
   logic oe_q;
   // length of the present drive-low stretch, counted only with supply present
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         hold_q <= '0;
      else if (!reset_pin_oe || !supply_good)
         hold_q <= '0;
      else
         hold_q <= hold_q + 32'h1;
   end
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         supply_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else
      begin
         supply_q <= supply_good;
         oe_q <= reset_pin_oe;
      end
   end
   // marks a supply return with a running oscillator until the pin is let go
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         recover_q <= 1'b0;
      else if (supply_good && !supply_q && osc_running)
         recover_q <= 1'b1;
      else if (!reset_pin_oe && oe_q)
         recover_q <= 1'b0;
   end

   chk_irq_route_high: assert property ((interrupt_control_select && alarm_irq) [*4] |-> alarm_irq_or_square_wave)
      else $error("alarm level not routed to output");
   chk_irq_route_low: assert property ((interrupt_control_select && !alarm_irq) [*4] |-> !alarm_irq_or_square_wave)
      else $error("idle alarm not routed to output");
   chk_osc_stopped: assert property (oscillator_enable_n [*4] |-> !osc_running)
      else $error("oscillator runs while disabled");
   chk_seconds_bcd: assert property (time_now.seconds[3:0] <= 4'h9 && time_now.seconds <= 8'h59)
      else $error("seconds not valid decimal");
   chk_date_range: assert property (time_now.date[3:0] <= 4'h9 && time_now.date <= 8'h31 && time_now.date != 8'h00)
      else $error("date out of range");
   chk_tick_spacing: assert property ($changed(time_now.seconds) |=> $stable(time_now.seconds) [*8])
      else $error("seconds changed twice within a few cycles");
   chk_comp_single: assert property (comp_request |=> !comp_request [*8])
      else $error("compensation request repeated");
   chk_pin_low_only: assert property (reset_pin_oe |-> !reset_pin_out)
      else $error("reset pin driven high");
   chk_button_catch: assert property (supply_good && !reset_pin_oe && $fell(reset_pin_in) |-> ##[1:5] reset_pin_oe)
      else $error("button press not answered by pin drive");
   chk_recover_hold: assert property ($fell(reset_pin_oe) && recover_q |-> hold_q >= HOLD_CNT - 1 && hold_q <= HOLD_CNT + 2)
      else $error("recovery hold length wrong");
   chk_skip_hold: assert property ($rose(supply_good) && !osc_running |-> !reset_pin_oe [*8])
      else $error("recovery hold applied with oscillator stopped");
endmodule

bind rtc_core rtc_core_chk #(.HOLD_CNT(HOLD_CNT)) rtc_core_chk_i (.clk(clk), .reset_n(reset_n),
   .supply_good(supply_good), .oscillator_enable_n(oscillator_enable_n),
   .interrupt_control_select(interrupt_control_select), .alarm_irq(alarm_irq), .reset_pin_in(reset_pin_in),
   .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe), .alarm_irq_or_square_wave(alarm_irq_or_square_wave),
   .osc_running(osc_running), .comp_request(comp_request), .time_now(time_now));
`default_nettype wire

/* File: rtc_pkg.sv */
`default_nettype none
package rtc_pkg;
   // register pointer map
   localparam logic [7:0] REG_SECONDS = 8'h00;
   localparam logic [7:0] REG_MINUTES = 8'h01;
   localparam logic [7:0] REG_HOURS = 8'h02;
   localparam logic [7:0] REG_WEEKDAY = 8'h03;
   localparam logic [7:0] REG_DATE = 8'h04;
   localparam logic [7:0] REG_MONTH = 8'h05;
   localparam logic [7:0] REG_YEAR = 8'h06;
   localparam logic [7:0] REG_LAST = 8'h12;
   localparam logic [7:0] SRAM_FIRST = 8'h14;
   localparam int SRAM_BYTES = 236;
   // hours and month field positions
   localparam int HOUR_MODE12_BIT = 6;
   localparam int HOUR_PM_BIT = 5;
   localparam int MONTH_CENTURY_BIT = 7;
   // reset values of the calendar
   localparam logic [7:0] RST_SECONDS = 8'h00;
   localparam logic [7:0] RST_MINUTES = 8'h00;
   localparam logic [7:0] RST_HOURS = 8'h00;
   localparam logic [7:0] RST_WEEKDAY = 8'h01;
   localparam logic [7:0] RST_DATE = 8'h01;
   localparam logic [7:0] RST_MONTH = 8'h01;
   localparam logic [7:0] RST_YEAR = 8'h00;
   // timing
   localparam int CLK_HZ = 125_000_000;
   localparam int HOLD_MS = 250;
   localparam int HOLD_CYCLES = CLK_HZ / 1000 * HOLD_MS;
   localparam int COMP_DELAY_S = 2;
   localparam int DEBOUNCE_MS = 250;
   localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int RST_PULSE_MS = 250;
   localparam int RST_PULSE_CYCLES = CLK_HZ / 1000 * RST_PULSE_MS;

   typedef struct packed {
      logic [7:0] seconds;
      logic [7:0] minutes;
      logic [7:0] hours;
      logic [7:0] weekday;
      logic [7:0] date;
      logic [7:0] month;
      logic [7:0] year;
   } time_t;

   typedef struct packed {
      logic start;
      logic wr;
      logic rd;
      logic [7:0] data;
   } bus_req_t;

   typedef enum logic [2:0] {
      SUP_IDLE = 3'b000,
      SUP_DEBOUNCE = 3'b001,
      SUP_WAIT_RISE = 3'b010,
      SUP_PULSE = 3'b011,
      SUP_PFAIL = 3'b100,
      SUP_RECOVER = 3'b101
   } sup_state_t;
endpackage
`default_nettype wire

/* File: testbench.sv */
`default_nettype none
module testbench;
   import rtc_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TICK = 100;
   localparam int HOLD = 20;
   localparam int DEB = 8;
   localparam int PULSE = 12;
   localparam time_t T_RST = '{RST_SECONDS, RST_MINUTES, RST_HOURS, RST_WEEKDAY, RST_DATE, RST_MONTH, RST_YEAR};
   localparam time_t T_HOLD = '{8'h42, 8'h17, 8'h08, 8'h02, 8'h15, 8'h06, 8'h30};
   // century year end, 12-hour midnight, leap February, 30-day month
   time_t set_tbl [4] = '{'{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99},
      '{8'h59, 8'h59, 8'h71, 8'h03, 8'h31, 8'h12, 8'h05}, '{8'h59, 8'h59, 8'h23, 8'h02, 8'h28, 8'h02, 8'h04},
      '{8'h59, 8'h59, 8'h23, 8'h05, 8'h30, 8'h04, 8'h23}};
   time_t exp_tbl [4] = '{'{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h81, 8'h00},
      '{8'h00, 8'h00, 8'h52, 8'h04, 8'h01, 8'h01, 8'h06}, '{8'h00, 8'h00, 8'h00, 8'h03, 8'h29, 8'h02, 8'h04},
      '{8'h00, 8'h00, 8'h00, 8'h06, 8'h01, 8'h05, 8'h23}};
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic reset_n = 1'b0;
   logic link_reset_n = 1'b0;
   logic supply_good = 1'b0;
   logic oscillator_enable_n = 1'b0;
   logic interrupt_control_select = 1'b0;
   logic alarm_irq = 1'b0;
   logic button_down = 1'b0;
   wire logic reset_pin_in;
   logic reset_pin_out, reset_pin_oe, alarm_irq_or_square_wave, osc_running, comp_request, prev;
   logic [7:0] link_rdata;
   bus_req_t link_req;
   time_t time_now;
   int failures = 0;
   int checks_done = 0;
   int n, i, edges;
   // pulled-up pin: low while the core drives it or the button is held
   assign reset_pin_in = !(reset_pin_oe && !reset_pin_out) && !button_down;
   always #4 clk = ~clk;
   initial #1.7 forever #3 link_clk = ~link_clk;

   rtc_core #(.TICK_CYCLES(TICK), .HOLD_CNT(HOLD), .DEBOUNCE_CNT(DEB), .PULSE_CNT(PULSE)) rtc_core_i (
      .clk(clk), .reset_n(reset_n), .link_clk(link_clk), .link_reset_n(link_reset_n), .link_req(link_req),
      .link_rdata(link_rdata), .supply_good(supply_good), .oscillator_enable_n(oscillator_enable_n),
      .interrupt_control_select(interrupt_control_select), .alarm_irq(alarm_irq), .reset_pin_in(reset_pin_in),
      .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe), .alarm_irq_or_square_wave(alarm_irq_or_square_wave),
      .osc_running(osc_running), .comp_request(comp_request), .time_now(time_now));
   link_master link_master_i (.link_clk(link_clk), .link_req(link_req));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic check_time(input time_t seen, input time_t exp);
      check({8'h00, seen}, {8'h00, exp});
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic cycles(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   task automatic bound_hit(input int k, input int lim);
      if (k >= lim)
      begin
         failures++;
         stop_test();
      end
   endtask
   task automatic wait_oe(input logic lvl, input int lim);
      for (n = 0; n < lim && reset_pin_oe !== lvl; n++)
         cycles(1);
      bound_hit(n, lim);
   endtask
   // seconds first, the rest back to back well inside one tick
   task automatic set_time(input time_t t);
      link_master_i.begin_at(REG_SECONDS);
      for (int k = 6; k >= 0; k--)
         link_master_i.put(t[k*8 +: 8]);
      cycles(4);
   endtask

   initial
   begin
      cycles(16);
      reset_n = 1'b1;
      link_reset_n = 1'b1;
      cycles(20);
      check_time(time_now, T_RST);
      check(64'(osc_running), 64'h0);
      supply_good = 1'b1;
      for (n = 0; n < 3 * TICK && comp_request !== 1'b1; n++)
         cycles(1);
      check(64'(n >= 2 * TICK - 10 && n <= 2 * TICK + 15), 64'h1);
      check(64'(osc_running), 64'h1);
      check(64'(reset_pin_oe), 64'h0);
      for (i = 0; i < 4; i++)
      begin
         cycles(TICK / 2); // keep the seconds write well clear of a tick
         set_time(set_tbl[i]);
         for (n = 0; n < 2 * TICK && time_now.seconds !== 8'h00; n++)
            cycles(1);
         bound_hit(n, 2 * TICK);
         cycles(2);
         check_time(time_now, exp_tbl[i]);
      end
      oscillator_enable_n = 1'b1;
      cycles(8);
      check(64'(osc_running), 64'h0);
      set_time(T_HOLD);
      cycles(3 * TICK);
      check_time(time_now, T_HOLD);
      link_master_i.begin_at(REG_LAST);
      link_master_i.step();
      check(64'(link_rdata), 64'h42);
      link_master_i.step();
      check(64'(link_rdata), 64'h17);
      oscillator_enable_n = 1'b0;
      link_master_i.begin_at(REG_SECONDS);
      cycles(3 * TICK);
      check(64'(link_rdata), 64'h42);
      check(64'(time_now.seconds != 8'h42), 64'h1);
      link_master_i.begin_at(SRAM_FIRST);
      link_master_i.put(8'haa);
      link_master_i.put(8'h55);
      link_master_i.begin_at(8'hff);
      link_master_i.put(8'hc3);
      link_master_i.begin_at(8'h07);
      link_master_i.put(8'h5a);
      // link-side reset alone: user memory must survive it
      link_reset_n = 1'b0;
      cycles(2);
      link_reset_n = 1'b1;
      cycles(2);
      check(64'(link_rdata), 64'h00);
      link_master_i.begin_at(SRAM_FIRST);
      check(64'(link_rdata), 64'haa);
      link_master_i.step();
      check(64'(link_rdata), 64'h55);
      link_master_i.begin_at(8'hff);
      check(64'(link_rdata), 64'hc3);
      link_master_i.begin_at(8'h07);
      check(64'(link_rdata), 64'h00);
      cycles(1);
      interrupt_control_select = 1'b1;
      alarm_irq = 1'b1;
      cycles(6);
      check(64'(alarm_irq_or_square_wave), 64'h1);
      alarm_irq = 1'b0;
      cycles(6);
      check(64'(alarm_irq_or_square_wave), 64'h0);
      interrupt_control_select = 1'b0;
      cycles(4);
      edges = 0;
      for (n = 0; n < 3 * TICK; n++)
      begin
         prev = alarm_irq_or_square_wave;
         cycles(1);
         edges += int'(alarm_irq_or_square_wave !== prev);
      end
      check(64'(edges >= 5 && edges <= 7), 64'h1);
      button_down = 1'b1;
      cycles(6);
      check(64'(reset_pin_oe), 64'h1);
      cycles(DEB + 6);
      check(64'(reset_pin_oe), 64'h0);
      button_down = 1'b0;
      wait_oe(1'b1, 10);
      wait_oe(1'b0, 4 * PULSE);
      check(64'(n >= PULSE - 2 && n <= PULSE + 3), 64'h1);
      supply_good = 1'b0;
      cycles(10);
      supply_good = 1'b1;
      wait_oe(1'b1, 10);
      wait_oe(1'b0, 4 * HOLD);
      check(64'(n >= HOLD - 2 && n <= HOLD + 3), 64'h1);
      stop_test();
   end
endmodule
`default_nettype wire
